// >>> tmc_defines.svh
// Constants for the die thermal monitor controller: offsets, fields, resets, timing.
// Assumes a 10 MHz system clock; included by bare name.
`ifndef TMC_DEFINES_SVH
`define TMC_DEFINES_SVH

// ****************************************
// Timing
// ****************************************
`define TMC_CLK_MHZ            10
`define TMC_DB_TIME_US         10
`define TMC_DB_CYC             (`TMC_DB_TIME_US * `TMC_CLK_MHZ)
`define TMC_SAMPLE_INTERVAL_US 3000
`define TMC_SAMPLE_WINDOW_US   450

// ****************************************
// Register map
// ****************************************
`define TMC_REG_CTRL  4'h0
`define TMC_REG_MASK  4'h4
`define TMC_REG_FLAG  4'h8
`define TMC_REG_SENSE 4'hC

// ****************************************
// Fields and reset values
// ****************************************
`define TMC_NUM_WARN     6
`define TMC_CTRL_EN_BIT  0
`define TMC_CTRL_AON_BIT 1
`define TMC_SENSE_SD_BIT 6
`define TMC_SENSE_PWR_BIT 7
`define TMC_CTRL_RST     2'h1
`define TMC_MASK_RST     6'h00

`endif

// >>> tmc_pkg.sv
// Types shared by the die thermal monitor controller.
// Assumes nothing of its surroundings.
package tmc_pkg;
    // Sensor power mode, Gray along off -> sampled -> continuous
    typedef enum logic [1:0] {
        TMC_PWR_OFF    = 2'h0,
        TMC_PWR_SAMPLE = 2'h1,
        TMC_PWR_CONT   = 2'h3
    } tmc_pwr_t;
endpackage

// >>> tmc_debounce.sv
// One comparator input: three-flop synchroniser and bidirectional debounce.
// Assumes an asynchronous input; counting only while advance is high.
`timescale 1ns/10ps
`include "tmc_defines.svh"
module tmc_debounce
    import tmc_pkg::*;
(
    // Clock and reset
    input  wire logic sys_clk,
    input  wire logic rst,
    // Raw input and gating
    input  wire logic raw_in,
    input  wire logic advance,
    // Debounced level
    output logic      level_q
);
    localparam logic [7:0] DB_CYC = 8'(`TMC_DB_CYC);

    logic       s1_q;
    logic       s2_q;
    logic       s3_q;
    logic [7:0] cnt_q;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
        end else begin
            s1_q <= raw_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // Frozen while the sensor is unpowered, so the last result is held
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cnt_q   <= 8'h00;
            level_q <= 1'b0;
        end else if (advance) begin
            if (s2_q == s3_q && s3_q != level_q) begin
                if (cnt_q == DB_CYC - 8'h01) begin
                    level_q <= s3_q;
                    cnt_q   <= 8'h00;
                end else begin
                    cnt_q <= cnt_q + 8'h01;
                end
            end else begin
                cnt_q <= 8'h00;
            end
        end
    end

    a_db_full_time: assert property (@(posedge sys_clk) disable iff (rst)
        $changed(level_q) |-> $past(cnt_q) == DB_CYC - 8'h01)
        else $error("debounced level changed early");
    a_db_hold_off: assert property (@(posedge sys_clk) disable iff (rst)
        !advance |=> $stable(level_q))
        else $error("level moved while unpowered");
endmodule

// >>> tmc_sample_timer.sv
// Sampling-mode timebase: a window at the start of every interval.
// Assumes run is low outside sampling mode; the counter restarts on entry.
`timescale 1ns/10ps
`include "tmc_defines.svh"
module tmc_sample_timer
    import tmc_pkg::*;
#(
    parameter logic [15:0] INTERVAL_CYC = 16'h7530,
    parameter logic [15:0] WINDOW_CYC   = 16'h1194
) (
    // Clock and reset
    input  wire logic sys_clk,
    input  wire logic rst,
    // Control
    input  wire logic run,
    // Window active
    output logic      window_q
);
    logic [15:0] cnt_q;

    always_ff @(posedge sys_clk) begin
        if (rst || !run) begin
            cnt_q <= 16'h0000;
        end else if (cnt_q == INTERVAL_CYC - 16'h0001) begin
            cnt_q <= 16'h0000;
        end else begin
            cnt_q <= cnt_q + 16'h0001;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            window_q <= 1'b0;
        end else begin
            window_q <= run && (cnt_q < WINDOW_CYC);
        end
    end

    a_smp_off_part: assert property (@(posedge sys_clk) disable iff (rst)
        run && cnt_q >= WINDOW_CYC && $past(run) |=> !window_q)
        else $error("window open outside its slot");
endmodule

// >>> tmc_top.sv
// Die thermal monitor controller: debounce, sense, flags, mask, shutdown, power.
// Assumes centre-die comparators and a standby pin arriving asynchronously,
// and an Avalon-MM master on sys_clk.
//
// Overview of operation
// - Upward threshold crossing sets its latched flag
// - Six warning levels, each flag, sense, mask
// - Sense releases only on hysteresis comparator
// - Shutdown holds until cooled past hysteresis
// - Only centre-die comparators feed this block
// - Enable bit zero powers the monitor off
// - Run: always-on bit picks continuous or sampled
// - Sampled: powered 450 us every 3 ms
// - Standby forces sampling while enabled
// - Debounce every comparator 10 us both ways
// - Unmasked set flag drives interrupt low
`timescale 1ns/10ps
`include "tmc_defines.svh"
module tmc_top
    import tmc_pkg::*;
#(
    parameter int SAMPLE_INTERVAL_CYC = `TMC_SAMPLE_INTERVAL_US * `TMC_CLK_MHZ,
    parameter int SAMPLE_WINDOW_CYC   = `TMC_SAMPLE_WINDOW_US * `TMC_CLK_MHZ
) (
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst,
    // Avalon-MM slave
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    // Centre-of-die comparators, asynchronous
    input  wire logic [5:0]  warn_hi_cmp,
    input  wire logic [5:0]  warn_rel_cmp,
    input  wire logic        sd_hi_cmp,
    input  wire logic        sd_cool_cmp,
    // System state, asynchronous, high in standby
    input  wire logic        standby_pin,
    // Outputs
    output logic             irq_out_n,
    output logic             thermal_shutdown,
    output logic             sensor_power_en
);
    localparam int         NW       = `TMC_NUM_WARN;
    localparam logic [1:0] CTRL_RST = `TMC_CTRL_RST;

    // ****************************************
    // Registers and state
    // ****************************************
    logic          temp_monitor_enable_q;
    logic          temp_monitor_always_on_q;
    logic [NW-1:0] warn_mask_q;
    logic [NW-1:0] warn_irq_flag_q;
    logic [NW-1:0] warn_sense_bit_q;
    logic [NW-1:0] warn_sense_bit_d;
    logic [NW-1:0] hi_db;
    logic [NW-1:0] rel_db;
    logic          sd_hi_db;
    logic          sd_cool_db;
    logic          standby_db;
    logic          window;
    tmc_pwr_t      pwr_q;
    tmc_pwr_t      pwr_d;
    logic          wr_take;
    logic          rd_take;
    logic [NW-1:0] flag_clr;
    logic [31:0]   rd_mux;

    // ****************************************
    // Comparator conditioning
    // ****************************************
    // Only centre-die comparators enter; other sensors stay analog readout
    genvar gi;
    generate
        for (gi = 0; gi < NW; gi++) begin : g_warn
            tmc_debounce u_hi (
                .sys_clk (sys_clk),
                .rst     (rst),
                .raw_in  (warn_hi_cmp[gi]),
                .advance (sensor_power_en),
                .level_q (hi_db[gi])
            );
            tmc_debounce u_rel (
                .sys_clk (sys_clk),
                .rst     (rst),
                .raw_in  (warn_rel_cmp[gi]),
                .advance (sensor_power_en),
                .level_q (rel_db[gi])
            );
        end
    endgenerate

    tmc_debounce u_sd_hi (
        .sys_clk (sys_clk),
        .rst     (rst),
        .raw_in  (sd_hi_cmp),
        .advance (sensor_power_en),
        .level_q (sd_hi_db)
    );
    tmc_debounce u_sd_cool (
        .sys_clk (sys_clk),
        .rst     (rst),
        .raw_in  (sd_cool_cmp),
        .advance (sensor_power_en),
        .level_q (sd_cool_db)
    );
    tmc_debounce u_standby (
        .sys_clk (sys_clk),
        .rst     (rst),
        .raw_in  (standby_pin),
        .advance (1'b1),
        .level_q (standby_db)
    );

    // ****************************************
    // Power mode
    // ****************************************
    always_comb begin
        case (pwr_q)
            TMC_PWR_OFF, TMC_PWR_SAMPLE, TMC_PWR_CONT: begin
                if (!temp_monitor_enable_q) begin
                    pwr_d = TMC_PWR_OFF;
                end else if (temp_monitor_always_on_q && !standby_db) begin
                    pwr_d = TMC_PWR_CONT;
                end else begin
                    pwr_d = TMC_PWR_SAMPLE;
                end
            end
            default: pwr_d = TMC_PWR_OFF;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            pwr_q <= TMC_PWR_OFF;
        end else begin
            pwr_q <= pwr_d;
        end
    end

    tmc_sample_timer #(
        .INTERVAL_CYC (16'(SAMPLE_INTERVAL_CYC)),
        .WINDOW_CYC   (16'(SAMPLE_WINDOW_CYC))
    ) u_timer (
        .sys_clk  (sys_clk),
        .rst      (rst),
        .run      (pwr_q == TMC_PWR_SAMPLE),
        .window_q (window)
    );

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            sensor_power_en <= 1'b0;
        end else begin
            sensor_power_en <= (pwr_q == TMC_PWR_CONT) || (pwr_q == TMC_PWR_SAMPLE && window);
        end
    end

    // ****************************************
    // Sense, flags, interrupt
    // ****************************************
    // Set by the upper comparator, released only when the lower one drops
    generate
        for (gi = 0; gi < NW; gi++) begin : g_sense
            always_comb begin
                if (hi_db[gi]) begin
                    warn_sense_bit_d[gi] = 1'b1;
                end else if (!rel_db[gi]) begin
                    warn_sense_bit_d[gi] = 1'b0;
                end else begin
                    warn_sense_bit_d[gi] = warn_sense_bit_q[gi];
                end
            end
        end
    endgenerate

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            warn_sense_bit_q <= 6'h00;
        end else begin
            warn_sense_bit_q <= warn_sense_bit_d;
        end
    end

    assign flag_clr = (wr_take && avs_address == `TMC_REG_FLAG) ? avs_writedata[NW-1:0] : 6'h00;

    // A crossing in the clearing cycle is kept: set wins
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            warn_irq_flag_q <= 6'h00;
        end else begin
            warn_irq_flag_q <= (warn_sense_bit_d & ~warn_sense_bit_q)
                             | (warn_irq_flag_q & ~flag_clr);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            irq_out_n <= 1'b1;
        end else begin
            irq_out_n <= ~|(warn_irq_flag_q & ~warn_mask_q);
        end
    end

    // Restart is blocked for as long as this stays high
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            thermal_shutdown <= 1'b0;
        end else if (sd_hi_db) begin
            thermal_shutdown <= 1'b1;
        end else if (!sd_cool_db) begin
            thermal_shutdown <= 1'b0;
        end
    end

    // ****************************************
    // Avalon-MM slave
    // ****************************************
    // One wait cycle per access; readdata is captured as waitrequest falls
    assign wr_take = avs_write && !avs_waitrequest;
    assign rd_take = avs_read && !avs_waitrequest;

    always_comb begin
        rd_mux = 32'h0000_0000;
        case (avs_address)
            `TMC_REG_CTRL:  rd_mux[1:0] = {temp_monitor_always_on_q, temp_monitor_enable_q};
            `TMC_REG_MASK:  rd_mux[NW-1:0] = warn_mask_q;
            `TMC_REG_FLAG:  rd_mux[NW-1:0] = warn_irq_flag_q;
            `TMC_REG_SENSE: rd_mux[7:0] = {sensor_power_en, thermal_shutdown, warn_sense_bit_q};
            default:        rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h0000_0000;
        end else if ((avs_read || avs_write) && avs_waitrequest) begin
            avs_waitrequest <= 1'b0;
            avs_readdata    <= avs_read ? rd_mux : 32'h0000_0000;
        end else begin
            avs_waitrequest <= 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            temp_monitor_enable_q    <= CTRL_RST[`TMC_CTRL_EN_BIT];
            temp_monitor_always_on_q <= CTRL_RST[`TMC_CTRL_AON_BIT];
        end else if (wr_take && avs_address == `TMC_REG_CTRL) begin
            temp_monitor_enable_q    <= avs_writedata[`TMC_CTRL_EN_BIT];
            temp_monitor_always_on_q <= avs_writedata[`TMC_CTRL_AON_BIT];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            warn_mask_q <= `TMC_MASK_RST;
        end else if (wr_take && avs_address == `TMC_REG_MASK) begin
            warn_mask_q <= avs_writedata[NW-1:0];
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    a_flag_on_rise: assert property (@(posedge sys_clk) disable iff (rst)
        $rose(warn_sense_bit_q[0]) |-> warn_irq_flag_q[0])
        else $error("flag missed a crossing");
    a_flag_sticks: assert property (@(posedge sys_clk) disable iff (rst)
        warn_irq_flag_q[5] && !(wr_take && avs_address == `TMC_REG_FLAG) |=> warn_irq_flag_q[5])
        else $error("flag dropped without write");
    a_sense_hyst: assert property (@(posedge sys_clk) disable iff (rst)
        $fell(warn_sense_bit_q[2]) |-> $past(!rel_db[2] && !hi_db[2]))
        else $error("sense released above hysteresis");
    a_irq_mask_gate: assert property (@(posedge sys_clk) disable iff (rst)
        (warn_irq_flag_q & ~warn_mask_q) != 6'h00 |=> !irq_out_n)
        else $error("unmasked flag did not interrupt");
    a_irq_masked: assert property (@(posedge sys_clk) disable iff (rst)
        (warn_irq_flag_q & ~warn_mask_q) == 6'h00 |=> irq_out_n)
        else $error("interrupt without unmasked flag");
    a_sd_hold: assert property (@(posedge sys_clk) disable iff (rst)
        thermal_shutdown && sd_cool_db |=> thermal_shutdown)
        else $error("shutdown released before cooling");
    a_off_when_dis: assert property (@(posedge sys_clk) disable iff (rst)
        !temp_monitor_enable_q ##1 !temp_monitor_enable_q |=> !sensor_power_en)
        else $error("sensor powered while disabled");
    a_aon_cont: assert property (@(posedge sys_clk) disable iff (rst)
        temp_monitor_enable_q && temp_monitor_always_on_q && !standby_db |=> pwr_q == TMC_PWR_CONT)
        else $error("always-on not continuous");
    a_standby_smp: assert property (@(posedge sys_clk) disable iff (rst)
        temp_monitor_enable_q && standby_db |=> pwr_q == TMC_PWR_SAMPLE)
        else $error("standby not sampling");
    a_bus_one_wait: assert property (@(posedge sys_clk) disable iff (rst)
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("bus answer late");
endmodule

// >>> tmc_sensor_model.sv
// Behavioural centre-of-die sensor with its threshold comparators.
// Assumes the bench sets the die temperature in whole degrees C.
`timescale 1ns/10ps
module tmc_sensor_model (
    // Die temperature, degrees C
    input  int         temp_c,
    // Comparator outputs
    output logic [5:0] warn_hi_cmp,
    output logic [5:0] warn_rel_cmp,
    output logic       sd_hi_cmp,
    output logic       sd_cool_cmp
);
    // ****************************************
    // Comparators
    // ****************************************
    // Only the centre sensor is modelled; the others never reach the block
    always_comb begin
        for (int i = 0; i < 6; i++) begin
            warn_hi_cmp[i]  = temp_c > 80 + 15 * i;
            warn_rel_cmp[i] = temp_c > 75 + 15 * i;
        end
        sd_hi_cmp   = temp_c > 165;
        sd_cool_cmp = temp_c > 150;
    end
endmodule

// >>> test_die_thermal_monitor_ctrl.sv
// Self-checking bench for the die thermal monitor controller.
// Assumes the sensor model on the comparator pins and a short sampling timebase.
`timescale 1ns/10ps
`include "tmc_defines.svh"
module test_die_thermal_monitor_ctrl
    import tmc_pkg::*;
;
    // ****************************************
    // Signals
    // ****************************************
    logic        sys_clk         = 1'b0;
    logic        rst             = 1'b1;
    logic [3:0]  avs_address     = 4'h0;
    logic        avs_read        = 1'b0;
    logic        avs_write       = 1'b0;
    logic [31:0] avs_writedata   = 32'h0000_0000;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic [5:0]  warn_hi_cmp;
    logic [5:0]  warn_rel_cmp;
    logic        sd_hi_cmp;
    logic        sd_cool_cmp;
    logic        standby_pin     = 1'b0;
    logic        irq_out_n;
    logic        thermal_shutdown;
    logic        sensor_power_en;
    int          temp_c          = 25;
    int          errors          = 0;
    int          check_count     = 0;
    logic [5:0]  exp_sense       = 6'h00;
    logic [5:0]  exp_flag        = 6'h00;
    logic [5:0]  mask            = 6'h00;
    logic [5:0]  clr;
    logic        exp_sd          = 1'b0;
    logic        en              = 1'b1;
    logic [31:0] rd;
    int          temps[$]        = '{100, 92, 89, 170, 160, 149};

    always #50 sys_clk = ~sys_clk;

    // Small timebase keeps the run short: 40 of every 200 cycles powered
    tmc_top #(.SAMPLE_INTERVAL_CYC(200), .SAMPLE_WINDOW_CYC(40)) DUT (
        .sys_clk(sys_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .warn_hi_cmp(warn_hi_cmp), .warn_rel_cmp(warn_rel_cmp),
        .sd_hi_cmp(sd_hi_cmp), .sd_cool_cmp(sd_cool_cmp), .standby_pin(standby_pin),
        .irq_out_n(irq_out_n), .thermal_shutdown(thermal_shutdown), .sensor_power_en(sensor_power_en));

    tmc_sensor_model u_sensor (.temp_c(temp_c), .warn_hi_cmp(warn_hi_cmp), .warn_rel_cmp(warn_rel_cmp),
        .sd_hi_cmp(sd_hi_cmp), .sd_cool_cmp(sd_cool_cmp));

    // ****************************************
    // Tasks
    // ****************************************
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    // One Avalon access; request held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= wr;
        avs_read      <= !wr;
        do begin
            @(posedge sys_clk);
        end while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
    endtask

    task automatic count_pwr(input int e);
        int c;
        c = 0;
        repeat (200) begin
            @(posedge sys_clk);
            c += (sensor_power_en === 1'b1);
        end
        chk("powered cycles", e, c);
    endtask

    // New temperature, let debounce settle, then compare with the model
    task automatic step(input int t);
        int thr;
        temp_c <= t;
        cyc(130);
        if (en) begin
            for (int i = 0; i < 6; i++) begin
                thr = 80 + 15 * i;
                if (t > thr) begin
                    if (!exp_sense[i]) exp_flag[i] = 1'b1;
                    exp_sense[i] = 1'b1;
                end else if (t <= thr - 5) begin
                    exp_sense[i] = 1'b0;
                end
            end
            if (t > 165) exp_sd = 1'b1;
            else if (t <= 150) exp_sd = 1'b0;
        end
        bus(1'b0, `TMC_REG_SENSE, 32'h0000_0000);
        chk("sense", {exp_sd, exp_sense}, rd[6:0]);
        bus(1'b0, `TMC_REG_FLAG, 32'h0000_0000);
        chk("flags", exp_flag, rd);
        chk("shutdown", exp_sd, thermal_shutdown);
        chk("irq", !(|(exp_flag & ~mask)), irq_out_n);
        $display("test step %0d C done", t);
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        void'($urandom(56));
        cyc(16);
        rst <= 1'b0;
        bus(1'b0, `TMC_REG_CTRL, 32'h0000_0000);
        chk("ctrl reset", `TMC_CTRL_RST, rd);
        bus(1'b0, `TMC_REG_MASK, 32'h0000_0000);
        chk("mask reset", `TMC_MASK_RST, rd);
        bus(1'b0, `TMC_REG_FLAG, 32'h0000_0000);
        chk("flag reset", 32'h0000_0000, rd);
        bus(1'b0, 4'h2, 32'h0000_0000);
        chk("unmapped", 32'h0000_0000, rd);
        count_pwr(40);
        $display("test reset done");
        bus(1'b1, `TMC_REG_CTRL, 32'h0000_0003);
        cyc(4);
        count_pwr(200);
        foreach (temps[k]) step(temps[k]);
        // Random masks, temperatures and partial write-one clears
        repeat (6) begin
            mask = 6'($urandom);
            clr  = 6'($urandom);
            bus(1'b1, `TMC_REG_MASK, {26'h0, mask});
            step($urandom_range(175, 60));
            bus(1'b1, `TMC_REG_FLAG, {26'h0, clr});
            exp_flag = exp_flag & ~clr;
            bus(1'b0, `TMC_REG_FLAG, 32'h0000_0000);
            chk("flag clear", exp_flag, rd);
        end
        standby_pin <= 1'b1;
        cyc(300);
        count_pwr(40);
        en = 1'b0;
        bus(1'b1, `TMC_REG_CTRL, 32'h0000_0000);
        cyc(4);
        count_pwr(0);
        step(130);
        // Back to run with the sensor powered; standby has to debounce first
        en = 1'b1;
        standby_pin <= 1'b0;
        bus(1'b1, `TMC_REG_CTRL, 32'h0000_0003);
        cyc(800);
        // Re-enabled monitor now acts on the temperature it ignored while off
        step(130);
        step(120);
        report_and_stop;
    end

    // Whole run is about 4000 cycles; five times that means a hang
    initial begin
        cyc(20000);
        errors++;
        report_and_stop;
    end
endmodule
